//--- src/uepc_defs.vh
/*
  constants for the endpoint/pipe configuration block: register byte addresses,
  field positions, encodings and reset values.
  assumes inclusion by bare name from design files under src/.
*/
// How it works
// - the transactions-per-microframe field codes 1, 2 and 3 transactions, 0 is reserved.
// - that field takes writes only where the endpoint is high-bandwidth iso capable, else reads zero.
// - on non-isochronous endpoints the transaction count is ignored by the transfer logic.
// - endpoint kind codes control, iso, bulk, interrupt and clears on usb bus reset.
// - the auto bank switch bit enables automatic bank switching and clears on usb reset.
// - the direction bit is OUT at 0 and IN at 1, never IN for control, cleared on usb reset.
// - a pipe reset clears fifo, config, status and mask state but keeps the setup fields.
// - a pipe reset returns fifo counter and rx/tx state to idle but keeps the data toggle.
// - during a pipe reset the pipe stays enabled and its configuration stays in force; here pipeActive drops and the config/status/mask words are cleared.
// - writing zero to the reset bit ends the reset and frees the fifo for use.
// - writing one to a pipe enable bit enables that pipe.
// - writing zero to an enable bit disables the pipe, makes it inactive and clears its regs.
`ifndef UEPC_DEFS_VH
`define UEPC_DEFS_VH

// ********************
// register map
// ********************
`define UEPC_ADDR_EPCFG    32'h400ac100
`define UEPC_ADDR_PIPE     32'h400ac41c
`define UEPC_ADDR_PIPESEL  32'h400ac420
`define UEPC_ADDR_PIPESTAT 32'h400ac424

// ********************
// endpoint config fields
// ********************
`define UEPC_MEMORY_ALLOCATE_BIT     1
`define UEPC_BANK_LO       2
`define UEPC_BANK_HI       3
`define UEPC_SIZE_LO       4
`define UEPC_SIZE_HI       6
`define UEPC_DIR_BIT       8
`define UEPC_AUTO_BANK_SWITCH_BIT    9
`define UEPC_KIND_LO       11
`define UEPC_KIND_HI       12
`define UEPC_NTR_LO        13
`define UEPC_NTR_HI        14

`define UEPC_KIND_CTRL     2'h0
`define UEPC_KIND_ISO      2'h1
`define UEPC_KIND_BULK     2'h2
`define UEPC_KIND_INTR     2'h3
`define UEPC_NTR_NONE      2'h0
`define UEPC_NTR_ONE       2'h1

// ********************
// host pipe register
// ********************
`define UEPC_PEN_LO        0
`define UEPC_PRST_LO       16
`define UEPC_PIPE_STAT_LO  8

// ********************
// pipe state codes
// ********************
`define UEPC_PS_INACTIVE   2'h0
`define UEPC_PS_ACTIVE     2'h1
`define UEPC_PS_RESET      2'h2

`define UEPC_HTRANS_NONSEQ 2'h2
`define UEPC_HSIZE_WORD    3'h2
`define UEPC_WORD_ZERO     32'h00000000

`endif

//--- src/uepc_pipe.v
/*
  one host pipe: enable, fifo reset, transfer state, fifo counter, data toggle,
  and the resettable config/status/mask words.
  assumes the parent issues one-cycle write strobes on the pipe register.
*/
`timescale 1ns/1ps
`include "uepc_defs.vh"

module uepc_pipe #(
  parameter CNT_W = 8,
  parameter REG_W = 8
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // register writes
  input  wire             wrStb,
  input  wire             enBit,
  input  wire             rstBit,
  input  wire [REG_W-1:0] regWrData,
  input  wire             regWrStb,
  // transfer activity
  input  wire             xferPush,
  input  wire             toggleFlip,
  // state
  output reg              enable_q,
  output reg              fifoRst_q,
  output reg  [1:0]       pipeState_q,
  output reg  [CNT_W-1:0] fifoCnt_q,
  output reg              dataToggle_q,
  output reg  [REG_W-1:0] pipeRegs_q
);

  wire clearRegs = wrStb & (rstBit | ~enBit);

  always @(posedge clk) begin
    if (!rst_n) begin
      enable_q     <= 1'b0;
      fifoRst_q    <= 1'b0;
      pipeState_q  <= `UEPC_PS_INACTIVE;
      fifoCnt_q    <= {CNT_W{1'b0}};
      dataToggle_q <= 1'b0;
      pipeRegs_q   <= {REG_W{1'b0}};
    end else begin
      if (wrStb) begin
        enable_q  <= enBit;
        fifoRst_q <= rstBit;
      end
      // toggle survives a fifo reset on purpose
      if (toggleFlip && enable_q)
        dataToggle_q <= ~dataToggle_q;
      if (clearRegs)
        pipeRegs_q <= {REG_W{1'b0}};
      else if (regWrStb)
        pipeRegs_q <= regWrData;
      if ((wrStb && !enBit) || (!wrStb && !enable_q)) begin
        pipeState_q <= `UEPC_PS_INACTIVE;
        fifoCnt_q   <= {CNT_W{1'b0}};
      end else if ((wrStb && rstBit) || (!wrStb && fifoRst_q)) begin
        pipeState_q <= `UEPC_PS_RESET;
        fifoCnt_q   <= {CNT_W{1'b0}};
      end else begin
        pipeState_q <= `UEPC_PS_ACTIVE;
        if (xferPush)
          fifoCnt_q <= fifoCnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

//--- src/uepc_top.v
/*
  endpoint configuration and host pipe control with an ahb-lite register slave.
  assumes a single ahb-lite master with whole-word single transfers; usbReset
  is a one-cycle pulse synchronous to clk from the usb link logic.
*/
`timescale 1ns/1ps
`include "uepc_defs.vh"

module uepc_top #(
  parameter NPIPE    = 9,
  parameter CNT_W    = 8,
  parameter REG_W    = 8,
  parameter [9:0] HBISO_CAP = 10'h002
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // usb link events
  input  wire        usbReset,
  input  wire [NPIPE-1:0] xferPush,
  input  wire [NPIPE-1:0] toggleFlip,
  // endpoint and pipe controls seen by the transfer engine
  output reg  [1:0]  epNtrEffective,
  output reg         epAutoSwitch,
  output reg         epDirIn,
  output reg  [NPIPE-1:0] pipeActive
);

  // ********************
  // endpoint configuration fields
  // ********************
  reg [1:0] ntr_q;
  reg [1:0] kind_q;
  reg       auto_bank_switch_q;
  reg       dir_q;
  reg [2:0] size_q;
  reg [1:0] bank_q;
  reg       memory_allocate_q;
  reg [3:0] epSel_q;
  reg [3:0] pipeSel_q;

  // ********************
  // bus address phase capture
  // ********************
  reg        wrPend_q;
  reg [31:0] wrAddr_q;
  wire addrPhase = hsel & hready & (htrans == `UEPC_HTRANS_NONSEQ);

  always @(posedge clk) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= `UEPC_WORD_ZERO;
    end else begin
      wrPend_q <= addrPhase & hwrite;
      if (addrPhase)
        wrAddr_q <= haddr;
    end
  end

  wire wrEp   = wrPend_q & (wrAddr_q == `UEPC_ADDR_EPCFG);
  wire wrPipe = wrPend_q & (wrAddr_q == `UEPC_ADDR_PIPE);
  wire wrSel  = wrPend_q & (wrAddr_q == `UEPC_ADDR_PIPESEL);
  wire wrStat = wrPend_q & (wrAddr_q == `UEPC_ADDR_PIPESTAT);

  // ********************
  // endpoint config register
  // ********************
  wire [1:0] wrKind = hwdata[`UEPC_KIND_HI:`UEPC_KIND_LO];
  wire       capSel = HBISO_CAP[epSel_q];

  always @(posedge clk) begin
    if (!rst_n) begin
      ntr_q    <= `UEPC_NTR_NONE;
      kind_q   <= `UEPC_KIND_CTRL;
      auto_bank_switch_q <= 1'b0;
      dir_q    <= 1'b0;
      size_q   <= 3'h0;
      bank_q   <= 2'h0;
      memory_allocate_q  <= 1'b0;
      epSel_q  <= 4'h1;
    end else if (usbReset) begin
      kind_q   <= `UEPC_KIND_CTRL;
      auto_bank_switch_q <= 1'b0;
      dir_q    <= 1'b0;
    end else if (wrEp) begin
      if (capSel)
        ntr_q <= hwdata[`UEPC_NTR_HI:`UEPC_NTR_LO];
      else
        ntr_q <= `UEPC_NTR_NONE;
      kind_q   <= wrKind;
      auto_bank_switch_q <= hwdata[`UEPC_AUTO_BANK_SWITCH_BIT];
      // a control endpoint cannot be IN, so the bit is forced to OUT
      dir_q    <= hwdata[`UEPC_DIR_BIT] & (wrKind != `UEPC_KIND_CTRL);
      size_q   <= hwdata[`UEPC_SIZE_HI:`UEPC_SIZE_LO];
      bank_q   <= hwdata[`UEPC_BANK_HI:`UEPC_BANK_LO];
      memory_allocate_q  <= hwdata[`UEPC_MEMORY_ALLOCATE_BIT];
    end else if (wrSel) begin
      epSel_q  <= hwdata[3:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      pipeSel_q <= 4'h0;
    end else if (wrSel) begin
      pipeSel_q <= hwdata[11:8];
    end
  end

  // ********************
  // pipes
  // ********************
  wire [NPIPE-1:0] pEn;
  wire [NPIPE-1:0] pRst;
  wire [NPIPE-1:0] pTog;
  wire [2*NPIPE-1:0]     pState;
  wire [CNT_W*NPIPE-1:0] pCnt;
  wire [REG_W*NPIPE-1:0] pRegs;

  genvar g;
  generate
    for (g = 0; g < NPIPE; g = g + 1) begin : gPipe
      uepc_pipe #(
        .CNT_W (CNT_W),
        .REG_W (REG_W)
      ) uPipe (
        .clk          (clk),
        .rst_n        (rst_n),
        .wrStb        (wrPipe),
        .enBit        (hwdata[`UEPC_PEN_LO + g]),
        .rstBit       (hwdata[`UEPC_PRST_LO + g]),
        .regWrData    (hwdata[REG_W-1:0]),
        .regWrStb     (wrStat && (pipeSel_q == g)),
        .xferPush     (xferPush[g]),
        .toggleFlip   (toggleFlip[g]),
        .enable_q     (pEn[g]),
        .fifoRst_q    (pRst[g]),
        .pipeState_q  (pState[2*g +: 2]),
        .fifoCnt_q    (pCnt[CNT_W*g +: CNT_W]),
        .dataToggle_q (pTog[g]),
        .pipeRegs_q   (pRegs[REG_W*g +: REG_W])
      );
    end
  endgenerate

  // ********************
  // read mux
  // ********************
  reg [31:0] rdNext;
  reg [3:0]  ps;
  always @* begin
    rdNext = `UEPC_WORD_ZERO;
    ps     = (pipeSel_q < NPIPE) ? pipeSel_q : 4'h0;
    case (haddr)
      `UEPC_ADDR_EPCFG: begin
        rdNext[`UEPC_NTR_HI:`UEPC_NTR_LO]   = ntr_q;
        rdNext[`UEPC_KIND_HI:`UEPC_KIND_LO] = kind_q;
        rdNext[`UEPC_AUTO_BANK_SWITCH_BIT]            = auto_bank_switch_q;
        rdNext[`UEPC_DIR_BIT]               = dir_q;
        rdNext[`UEPC_SIZE_HI:`UEPC_SIZE_LO] = size_q;
        rdNext[`UEPC_BANK_HI:`UEPC_BANK_LO] = bank_q;
        rdNext[`UEPC_MEMORY_ALLOCATE_BIT]             = memory_allocate_q;
      end
      `UEPC_ADDR_PIPE: begin
        rdNext[`UEPC_PEN_LO +: NPIPE]  = pEn;
        rdNext[`UEPC_PRST_LO +: NPIPE] = pRst;
      end
      `UEPC_ADDR_PIPESEL: begin
        rdNext[3:0]  = epSel_q;
        rdNext[11:8] = pipeSel_q;
      end
      `UEPC_ADDR_PIPESTAT: begin
        rdNext[REG_W-1:0] = pRegs[REG_W*ps +: REG_W];
        rdNext[`UEPC_PIPE_STAT_LO +: 2] = pState[2*ps +: 2];
        rdNext[`UEPC_PIPE_STAT_LO + 2]  = pTog[ps];
        rdNext[`UEPC_PRST_LO +: CNT_W]  = pCnt[CNT_W*ps +: CNT_W];
      end
      default: rdNext = `UEPC_WORD_ZERO;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      hrdata    <= `UEPC_WORD_ZERO;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addrPhase && !hwrite)
        hrdata <= rdNext;
    end
  end

  // ********************
  // controls to the transfer engine
  // ********************
  always @(posedge clk) begin
    if (!rst_n) begin
      epNtrEffective <= `UEPC_NTR_NONE;
      epAutoSwitch   <= 1'b0;
      epDirIn        <= 1'b0;
      pipeActive     <= {NPIPE{1'b0}};
    end else begin
      // the count only matters to isochronous traffic
      epNtrEffective <= (kind_q == `UEPC_KIND_ISO) ? ntr_q : `UEPC_NTR_ONE;
      epAutoSwitch   <= auto_bank_switch_q;
      epDirIn        <= dir_q;
      pipeActive     <= pEn & ~pRst;
    end
  end

endmodule

//--- bench/uepc_top_checker.sv
/* assertions on the uepc_top ports.
   assumes binding into uepc_top, one clock domain. */
`timescale 1ns/1ps
`include "uepc_defs.vh"
module uepc_top_checker #(
  parameter NPIPE = 9
) (
  // clock and reset
  input wire             clk,
  input wire             rst_n,
  // bus side
  input wire             hsel,
  input wire [31:0]      haddr,
  input wire [1:0]       htrans,
  input wire             hwrite,
  input wire             hready,
  input wire             hreadyout,
  input wire             hresp,
  // usb side
  input wire             usbReset,
  input wire [1:0]       epNtrEffective,
  input wire             epAutoSwitch,
  input wire             epDirIn,
  input wire [NPIPE-1:0] pipeActive
);
  reg  [3:0] cfgHist_q;
  reg  [3:0] pipHist_q;
  wire       take = hsel & hready & hwrite & (htrans == `UEPC_HTRANS_NONSEQ);
  // recent writes, so an output change can be traced to its cause
  always @(posedge clk) begin
    cfgHist_q <= rst_n ? {cfgHist_q[2:0], take & (haddr == `UEPC_ADDR_EPCFG)} : 4'h0;
    pipHist_q <= rst_n ? {pipHist_q[2:0], take & (haddr == `UEPC_ADDR_PIPE)} : 4'h0;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_ready_high: assert property (hreadyout)
    else $error("ready dropped");
  chk_resp_okay: assert property (!hresp)
    else $error("error response");
  chk_usb_auto: assert property (usbReset |-> ##[1:3] !epAutoSwitch)
    else $error("auto switch kept over usb reset");
  chk_usb_dir: assert property (usbReset |-> ##[1:3] !epDirIn)
    else $error("direction kept over usb reset");
  chk_usb_kind: assert property (usbReset |-> ##[1:3] epNtrEffective == 2'h1)
    else $error("kind not cleared by usb reset");
  chk_auto_cause: assert property ($rose(epAutoSwitch) |-> cfgHist_q != 4'h0)
    else $error("auto switch set without write");
  chk_dir_cause: assert property ($rose(epDirIn) |-> cfgHist_q != 4'h0)
    else $error("direction set without write");
  chk_pipe_cause: assert property ($changed(pipeActive) |-> pipHist_q != 4'h0)
    else $error("pipe activity changed without write");
  chk_reset_quiet: assert property ($rose(rst_n) |-> pipeActive == 0 && !epDirIn)
    else $error("outputs not idle after reset");
endmodule

bind uepc_top uepc_top_checker #(.NPIPE(NPIPE)) chk (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .usbReset(usbReset), .epNtrEffective(epNtrEffective),
  .epAutoSwitch(epAutoSwitch), .epDirIn(epDirIn), .pipeActive(pipeActive));

//--- bench/uepc_usb_peer.sv
/* far-side usb activity: bus reset, fifo pushes, toggle flips.
   assumes tasks are called by the bench; pulses last one clock. */
`timescale 1ns/1ps
module uepc_usb_peer #(
  parameter NPIPE = 9
) (
  // clock
  input  wire             clk,
  // link events
  output reg              usbReset,
  output reg  [NPIPE-1:0] xferPush,
  output reg  [NPIPE-1:0] toggleFlip
);
  initial begin
    usbReset = 1'b0;
    xferPush = 0;
    toggleFlip = 0;
  end
  task busReset;
    begin
      @(posedge clk) usbReset <= 1'b1;
      @(posedge clk) usbReset <= 1'b0;
    end
  endtask
  task push(input integer p);
    begin
      @(posedge clk) xferPush[p] <= 1'b1;
      @(posedge clk) xferPush <= 0;
    end
  endtask
  task flip(input integer p);
    begin
      @(posedge clk) toggleFlip[p] <= 1'b1;
      @(posedge clk) toggleFlip <= 0;
    end
  endtask
endmodule

//--- bench/uepc_top_tb.sv
/* self-checking bench for uepc_top.
   assumes a zero-wait slave and the usb peer model. */
`timescale 1ns/1ps
`include "uepc_defs.vh"
module uepc_top_tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [2:0]  hsize = `UEPC_HSIZE_WORD;
  reg  [31:0] hwdata = 32'h0;
  reg  [31:0] rd;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, usbReset, epAutoSwitch, epDirIn;
  wire [8:0]  xferPush, toggleFlip, pipeActive;
  wire [1:0]  epNtrEffective;
  integer     error_cnt = 0;
  integer     checks_done = 0;
  integer     i;
  always #4 clk = ~clk;
  uepc_usb_peer peer (.clk(clk), .usbReset(usbReset), .xferPush(xferPush),
    .toggleFlip(toggleFlip));
  uepc_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .usbReset(usbReset), .xferPush(xferPush),
    .toggleFlip(toggleFlip), .epNtrEffective(epNtrEffective), .epAutoSwitch(epAutoSwitch),
    .epDirIn(epDirIn), .pipeActive(pipeActive));
  // ****
  // bus and compare tasks
  // ****
  task check(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // one idle edge before each transfer keeps reads clear of the previous write
  task xfer(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge clk);
      htrans <= `UEPC_HTRANS_NONSEQ;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
    end
  endtask
  task rdChk(input [31:0] a, input [31:0] exp);
    begin
      xfer(1'b0, a, 32'h0);
      check(rd, exp);
    end
  endtask
  function [31:0] cfg(input [1:0] n, input [1:0] k, input au, input d);
    cfg = (n << `UEPC_NTR_LO) | (k << `UEPC_KIND_LO) | (au << `UEPC_AUTO_BANK_SWITCH_BIT)
        | (d << `UEPC_DIR_BIT) | (32'h1 << `UEPC_MEMORY_ALLOCATE_BIT);
  endfunction
  // ****
  // scenarios
  // ****
  task testReset;
    begin
      rdChk(`UEPC_ADDR_EPCFG, 32'h0);
      rdChk(`UEPC_ADDR_PIPE, 32'h0);
      rdChk(32'h400ac500, 32'h0);
      check(hresp, 32'h0);
    end
  endtask
  task testNtr;
    begin
      xfer(1'b1, `UEPC_ADDR_PIPESEL, 32'h1);
      // software side picks one more bank per extra transaction
      for (i = 1; i < 4; i = i + 1) begin
        xfer(1'b1, `UEPC_ADDR_EPCFG, cfg(i, `UEPC_KIND_ISO, 1'b0, 1'b1)
          | ((i - 1) << `UEPC_BANK_LO));
        rdChk(`UEPC_ADDR_EPCFG, cfg(i, `UEPC_KIND_ISO, 1'b0, 1'b1)
          | ((i - 1) << `UEPC_BANK_LO));
        check(epNtrEffective, i);
      end
      xfer(1'b1, `UEPC_ADDR_EPCFG, cfg(2'h3, `UEPC_KIND_BULK, 1'b0, 1'b1));
      rdChk(`UEPC_ADDR_EPCFG, cfg(2'h3, `UEPC_KIND_BULK, 1'b0, 1'b1));
      check(epNtrEffective, 32'h1);
      xfer(1'b1, `UEPC_ADDR_PIPESEL, 32'h0);
      xfer(1'b1, `UEPC_ADDR_EPCFG, cfg(2'h3, `UEPC_KIND_ISO, 1'b0, 1'b1));
      rdChk(`UEPC_ADDR_EPCFG, cfg(2'h0, `UEPC_KIND_ISO, 1'b0, 1'b1));
    end
  endtask
  task testKinds;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        xfer(1'b1, `UEPC_ADDR_EPCFG, cfg(2'h0, i, 1'b1, 1'b1));
        rdChk(`UEPC_ADDR_EPCFG, cfg(2'h0, i, 1'b1, i != 0));
        check(epDirIn, i != 0);
        check(epAutoSwitch, 32'h1);
      end
      peer.busReset;
      rdChk(`UEPC_ADDR_EPCFG, cfg(2'h0, 2'h0, 1'b0, 1'b0));
      check(epAutoSwitch, 32'h0);
      check(epDirIn, 32'h0);
    end
  endtask
  task testEnable;
    begin
      xfer(1'b1, `UEPC_ADDR_PIPE, 32'h1ff);
      rdChk(`UEPC_ADDR_PIPE, 32'h1ff);
      check(pipeActive, 32'h1ff);
      xfer(1'b1, `UEPC_ADDR_PIPESEL, 32'h300);
      xfer(1'b1, `UEPC_ADDR_PIPESTAT, 32'h5a);
      peer.push(3);
      rdChk(`UEPC_ADDR_PIPESTAT, 32'h1015a);
      xfer(1'b1, `UEPC_ADDR_PIPE, 32'h1f7);
      xfer(1'b0, `UEPC_ADDR_PIPESTAT, 32'h0);
      check(rd[15:0], 32'h0);
      check(pipeActive, 32'h1f7);
    end
  endtask
  task testPipeReset;
    begin
      xfer(1'b1, `UEPC_ADDR_PIPESEL, 32'h800);
      xfer(1'b1, `UEPC_ADDR_PIPESTAT, 32'ha5);
      peer.push(8);
      peer.flip(8);
      xfer(1'b1, `UEPC_ADDR_PIPE, 32'h10001f7);
      rdChk(`UEPC_ADDR_PIPESTAT, 32'h600);
      rdChk(`UEPC_ADDR_PIPE, 32'h10001f7);
      check(pipeActive, 32'h0f7);
      xfer(1'b1, `UEPC_ADDR_PIPE, 32'h1f7);
      peer.push(8);
      rdChk(`UEPC_ADDR_PIPESTAT, 32'h10500);
      check(pipeActive, 32'h1f7);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    testReset;
    testNtr;
    testKinds;
    testEnable;
    testPipeReset;
    wrap_up;
  end
  // the whole run needs under 150 cycles
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    wrap_up;
  end
endmodule
